// >>> hw/pstr_pkg.sv
// Package: register map, field positions and reset values of the steering block
package pstr_pkg;
    // ------------------------------------------------------------
    // Register byte offsets (APB, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_PWM_CAPTURE_CONTROL = 8'h00;
    localparam logic [7:0] OFF_CAPTURE_UNIT_TWO_CONTROL = 8'h04;
    localparam logic [7:0] OFF_DUTY_LOW_BYTE = 8'h08;
    localparam logic [7:0] OFF_DUTY_HIGH_BYTE = 8'h0C;
    localparam logic [7:0] OFF_SHUTDOWN_CONTROL = 8'h10;
    localparam logic [7:0] OFF_PERIOD_COMPARE = 8'h14;
    localparam logic [7:0] OFF_STEERING_CONTROL = 8'h18;
    localparam logic [7:0] OFF_RESTART_DEADBAND_CONTROL = 8'h1C;
    localparam logic [7:0] OFF_TIMEBASE_CONTROL = 8'h20;
    localparam logic [7:0] OFF_TIMEBASE_COUNT = 8'h24;
    localparam logic [7:0] OFF_ACTIVE_STEERING = 8'h28;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_PWM_CAPTURE_CONTROL = 8'h00;
    localparam logic [7:0] RST_CAPTURE_UNIT_TWO_CONTROL = 8'h00;
    localparam logic [7:0] RST_DUTY = 8'h00;
    localparam logic [7:0] RST_SHUTDOWN_CONTROL = 8'h00;
    localparam logic [7:0] RST_PERIOD_COMPARE = 8'hFF;
    localparam logic [7:0] RST_STEERING_CONTROL = 8'h01;
    localparam logic [7:0] RST_RESTART_DEADBAND_CONTROL = 8'h00;
    localparam logic [7:0] RST_TIMEBASE_CONTROL = 8'h00;
    localparam logic [7:0] RST_TIMEBASE_COUNT = 8'h00;
    // ------------------------------------------------------------
    // Implemented-bit masks and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_CAPTURE_UNIT_TWO = 8'h3F;
    localparam logic [7:0] MASK_STEERING = 8'h1F;
    localparam logic [7:0] MASK_TIMEBASE_CONTROL = 8'h7F;
    localparam int STEER_SYNC_SELECT_BIT = 4;
    localparam int TIMEBASE_ON_BIT = 2;
    localparam int SHUTDOWN_STATUS_BIT = 7;
    localparam logic [1:0] MODE_PWM = 2'h3;
    localparam logic [1:0] CONFIG_SINGLE = 2'h0;
    localparam logic [1:0] SHUT_DRIVE_HIGH = 2'h1;
endpackage

// >>> hw/pstr_steering.sv
// Pulse steering output stage with its APB register file
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/100ps
//
// Function
// - Sync bit 0: steering applies right after write
// - Immediate steering may truncate a running pulse
// - Sync bit 1: steering waits for next period
// - Synced steering yields only whole PWM periods
// - Unimplemented register bits read back as zero
// - Steering only in PWM single-output mode
// - Set enable drives PWM; cleared returns port
// - Shutdown forces only steered pins
module pstr_steering
    import pstr_pkg::*;
#(
    parameter int NUM_PINS = 4
)
(
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Raw PWM waveform and shutdown request from the PWM core
    input wire logic pwm_raw,
    input wire logic shutdown_evt,
    // Port latch values used when a pin is not steered
    input wire logic [NUM_PINS-1:0] port_out,
    // Pins: pwm_out_a..d as bits 0..3, with output enables
    output logic [NUM_PINS-1:0] pwm_out,
    output logic [NUM_PINS-1:0] pwm_out_oe
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0] pwm_capture_control_r, pwm_capture_control_nxt;
    logic [7:0] capture_unit_two_control_r, capture_unit_two_control_nxt;
    logic [7:0] duty_low_byte_r, duty_low_byte_nxt;
    logic [7:0] duty_high_byte_r, duty_high_byte_nxt;
    logic [7:0] shutdown_control_r, shutdown_control_nxt;
    logic [7:0] period_compare_r, period_compare_nxt;
    logic [7:0] steering_control_r, steering_control_nxt;
    logic [7:0] restart_deadband_control_r, restart_deadband_control_nxt;
    logic [7:0] timebase_control_r, timebase_control_nxt;
    logic [7:0] timebase_count_r, timebase_count_nxt;
    logic [NUM_PINS-1:0] steer_active_r, steer_active_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic [NUM_PINS-1:0] pin_r, pin_nxt;
    logic [NUM_PINS-1:0] oe_r, oe_nxt;

    logic wr_en;
    logic rd_en;
    logic period_match;
    logic steer_mode;
    logic pwm_pol;
    logic shut_active;

    // Address decode helper: true for a mapped register offset
    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a <= OFF_ACTIVE_STEERING) && (a[1:0] == 2'h0);
    endfunction

    // ------------------------------------------------------------
    // Bus qualifiers and timebase match
    // ------------------------------------------------------------
    // Zero-wait slave: access phase completes on its first cycle
    assign wr_en = psel && penable && pwrite && addr_mapped(paddr);
    // Reads fetch in the setup cycle so data stands beside pready
    assign rd_en = psel && !penable && !pwrite;
    // Period restarts when the count meets the period compare value
    assign period_match = timebase_control_r[TIMEBASE_ON_BIT]
        && (timebase_count_r == period_compare_r);
    // Single-output PWM mode selects steering
    assign steer_mode = (pwm_capture_control_r[3:2] == MODE_PWM)
        && (pwm_capture_control_r[7:6] == CONFIG_SINGLE);
    // Low mode bit 1 alone picks polarity: set inverts the waveform
    assign pwm_pol = pwm_raw ^ pwm_capture_control_r[1];
    assign shut_active = shutdown_control_r[SHUTDOWN_STATUS_BIT]
        || shutdown_evt;

    // ------------------------------------------------------------
    // Register file next state
    // ------------------------------------------------------------
    always_comb
    begin
        pwm_capture_control_nxt = pwm_capture_control_r;
        capture_unit_two_control_nxt = capture_unit_two_control_r;
        duty_low_byte_nxt = duty_low_byte_r;
        duty_high_byte_nxt = duty_high_byte_r;
        shutdown_control_nxt = shutdown_control_r;
        period_compare_nxt = period_compare_r;
        steering_control_nxt = steering_control_r;
        restart_deadband_control_nxt = restart_deadband_control_r;
        timebase_control_nxt = timebase_control_r;
        timebase_count_nxt = timebase_count_r;
        // Timebase runs and wraps at the period match
        if (period_match)
            timebase_count_nxt = 8'h00;
        else if (timebase_control_r[TIMEBASE_ON_BIT])
            timebase_count_nxt = timebase_count_r + 8'h01;
        if (wr_en)
        begin
            case (paddr)
                OFF_PWM_CAPTURE_CONTROL:
                    pwm_capture_control_nxt = pwdata[7:0];
                OFF_CAPTURE_UNIT_TWO_CONTROL:
                    capture_unit_two_control_nxt =
                        pwdata[7:0] & MASK_CAPTURE_UNIT_TWO;
                OFF_DUTY_LOW_BYTE:
                    duty_low_byte_nxt = pwdata[7:0];
                OFF_DUTY_HIGH_BYTE:
                    duty_high_byte_nxt = pwdata[7:0];
                OFF_SHUTDOWN_CONTROL:
                    shutdown_control_nxt = pwdata[7:0];
                OFF_PERIOD_COMPARE:
                    period_compare_nxt = pwdata[7:0];
                OFF_STEERING_CONTROL:
                    steering_control_nxt =
                        pwdata[7:0] & MASK_STEERING;
                OFF_RESTART_DEADBAND_CONTROL:
                    restart_deadband_control_nxt = pwdata[7:0];
                OFF_TIMEBASE_CONTROL:
                    timebase_control_nxt =
                        pwdata[7:0] & MASK_TIMEBASE_CONTROL;
                OFF_TIMEBASE_COUNT:
                    timebase_count_nxt = pwdata[7:0];
                default:
                    ;
            endcase
        end
        // A live shutdown level keeps the status bit set; set wins
        if (shutdown_evt)
            shutdown_control_nxt[SHUTDOWN_STATUS_BIT] = 1'b1;
    end

    // ------------------------------------------------------------
    // Active routing: immediate or at period start
    // ------------------------------------------------------------
    always_comb
    begin
        steer_active_nxt = steer_active_r;
        if (!steering_control_r[STEER_SYNC_SELECT_BIT])
            // Takes effect right after the write; may cut a pulse
            steer_active_nxt = steering_control_r[NUM_PINS-1:0];
        else if (period_match)
            // Pending copy moves over only at the period boundary
            steer_active_nxt = steering_control_r[NUM_PINS-1:0];
    end

    // ------------------------------------------------------------
    // Read data and answer
    // ------------------------------------------------------------
    always_comb
    begin
        prdata_nxt = prdata_r;
        pready_nxt = psel && !penable;
        pslverr_nxt = psel && !penable && !addr_mapped(paddr);
        if (rd_en)
        begin
            // Upper bits read zero for every register
            case (paddr)
                OFF_PWM_CAPTURE_CONTROL:
                    prdata_nxt = {24'h000000, pwm_capture_control_r};
                OFF_CAPTURE_UNIT_TWO_CONTROL:
                    prdata_nxt = {24'h000000, capture_unit_two_control_r};
                OFF_DUTY_LOW_BYTE:
                    prdata_nxt = {24'h000000, duty_low_byte_r};
                OFF_DUTY_HIGH_BYTE:
                    prdata_nxt = {24'h000000, duty_high_byte_r};
                OFF_SHUTDOWN_CONTROL:
                    prdata_nxt = {24'h000000, shutdown_control_r};
                OFF_PERIOD_COMPARE:
                    prdata_nxt = {24'h000000, period_compare_r};
                OFF_STEERING_CONTROL:
                    prdata_nxt = {24'h000000, steering_control_r};
                OFF_RESTART_DEADBAND_CONTROL:
                    prdata_nxt = {24'h000000, restart_deadband_control_r};
                OFF_TIMEBASE_CONTROL:
                    prdata_nxt = {24'h000000, timebase_control_r};
                OFF_TIMEBASE_COUNT:
                    prdata_nxt = {24'h000000, timebase_count_r};
                OFF_ACTIVE_STEERING:
                    prdata_nxt = 32'(steer_active_r);
                default:
                    prdata_nxt = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < NUM_PINS; i++)
        begin
            logic [1:0] sstate;
            sstate = (i % 2 == 0) ? shutdown_control_r[3:2]
                                  : shutdown_control_r[1:0];
            if (steer_mode && steer_active_r[i])
            begin
                if (shut_active)
                begin
                    // Only steered pins take the shutdown state
                    pin_nxt[i] = (sstate == SHUT_DRIVE_HIGH);
                    oe_nxt[i] = !sstate[1];
                end
                else
                begin
                    pin_nxt[i] = pwm_pol;
                    oe_nxt[i] = 1'b1;
                end
            end
            else
            begin
                // Port owns the pin; shutdown leaves it alone
                pin_nxt[i] = port_out[i];
                oe_nxt[i] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pwm_capture_control_r <= RST_PWM_CAPTURE_CONTROL;
            capture_unit_two_control_r <= RST_CAPTURE_UNIT_TWO_CONTROL;
            duty_low_byte_r <= RST_DUTY;
            duty_high_byte_r <= RST_DUTY;
            shutdown_control_r <= RST_SHUTDOWN_CONTROL;
            period_compare_r <= RST_PERIOD_COMPARE;
            steering_control_r <= RST_STEERING_CONTROL;
            restart_deadband_control_r <= RST_RESTART_DEADBAND_CONTROL;
            timebase_control_r <= RST_TIMEBASE_CONTROL;
            timebase_count_r <= RST_TIMEBASE_COUNT;
            steer_active_r <= NUM_PINS'(RST_STEERING_CONTROL);
            prdata_r <= 32'h00000000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            pin_r <= '0;
            oe_r <= '0;
        end
        else
        begin
            pwm_capture_control_r <= pwm_capture_control_nxt;
            capture_unit_two_control_r <= capture_unit_two_control_nxt;
            duty_low_byte_r <= duty_low_byte_nxt;
            duty_high_byte_r <= duty_high_byte_nxt;
            shutdown_control_r <= shutdown_control_nxt;
            period_compare_r <= period_compare_nxt;
            steering_control_r <= steering_control_nxt;
            restart_deadband_control_r <= restart_deadband_control_nxt;
            timebase_control_r <= timebase_control_nxt;
            timebase_count_r <= timebase_count_nxt;
            steer_active_r <= steer_active_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            pin_r <= pin_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign pwm_out = pin_r;
    assign pwm_out_oe = oe_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_IMMEDIATE: assert property (@(posedge pclk) disable iff (!presetn)
        !steering_control_r[STEER_SYNC_SELECT_BIT]
        |=> steer_active_r == $past(steering_control_r[NUM_PINS-1:0]))
        else $error("immediate steering not applied");
    AST_SYNC_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        steering_control_r[STEER_SYNC_SELECT_BIT] && !period_match
        |=> $stable(steer_active_r))
        else $error("synced steering changed mid period");
    AST_SYNC_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
        period_match |=> steer_active_r
            == $past(steering_control_r[NUM_PINS-1:0]))
        else $error("pending steering not loaded at period");
    AST_WHOLE: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(steer_active_r) && $past(steering_control_r[4])
        |-> $past(period_match, 1))
        else $error("synced steering changed off boundary");
    AST_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
        steering_control_r[7:5] == 3'h0
        && timebase_control_r[7] == 1'b0)
        else $error("unimplemented bits not zero");
    AST_PORT: assert property (@(posedge pclk) disable iff (!presetn)
        !steer_mode |=> pwm_out == $past(port_out))
        else $error("pins steered outside single mode");
    AST_PWM: assert property (@(posedge pclk) disable iff (!presetn)
        steer_mode && steer_active_r[0] && !shut_active
        |=> pwm_out[0] == $past(pwm_pol))
        else $error("steered pin lacks waveform");
    AST_SHUT: assert property (@(posedge pclk) disable iff (!presetn)
        shut_active && !steer_active_r[1]
        |=> pwm_out[1] == $past(port_out[1]))
        else $error("shutdown touched a port pin");
    AST_TRUNC: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == OFF_STEERING_CONTROL && !pwdata[4]
        |=> ##1 steer_active_r == $past(pwdata[3:0], 2))
        else $error("immediate write not routed");

endmodule

// >>> verification/pstr_load.sv
// Load model for the four steered pins, with a pull-down on each
`timescale 1ns/100ps
module pstr_load
(
    // Pin drive from the block
    input wire logic [3:0] drive,
    input wire logic [3:0] drive_en,
    // Level seen at the loads
    output logic [3:0] level
);
    // ------------------------------------------------------------
    // Pin resolution
    // ------------------------------------------------------------
    // Released pins fall to the pull-down, never keep the last value
    always_comb
    begin
        level = drive & drive_en;
    end
endmodule

// >>> verification/pwm_pulse_steering_sync_tb.sv
// Self-checking bench for the pulse steering block
`timescale 1ns/100ps
module pwm_pulse_steering_sync_tb;
    import pstr_pkg::*;
    // ------------------------------------------------------------
    // Signals and model state
    // ------------------------------------------------------------
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pwm_raw, shutdown_evt, raw_m, evt_m;
    logic [3:0] port_out, pwm_out, pwm_out_oe, level, port_m;
    logic [7:0] cfg_m, act_m, sdc_m;
    logic [31:0] rng = 32'h0000_9A69;
    int errors = 0;
    int samples_checked = 0;
    // Count sits before control so the timer is still off when read
    logic [7:0] offs [10] = '{OFF_PWM_CAPTURE_CONTROL,
        OFF_CAPTURE_UNIT_TWO_CONTROL, OFF_DUTY_LOW_BYTE, OFF_DUTY_HIGH_BYTE,
        OFF_SHUTDOWN_CONTROL, OFF_PERIOD_COMPARE, OFF_STEERING_CONTROL,
        OFF_RESTART_DEADBAND_CONTROL, OFF_TIMEBASE_COUNT,
        OFF_TIMEBASE_CONTROL};
    logic [7:0] rsts [10] = '{RST_PWM_CAPTURE_CONTROL,
        RST_CAPTURE_UNIT_TWO_CONTROL, RST_DUTY, RST_DUTY,
        RST_SHUTDOWN_CONTROL, RST_PERIOD_COMPARE, RST_STEERING_CONTROL,
        RST_RESTART_DEADBAND_CONTROL, RST_TIMEBASE_COUNT,
        RST_TIMEBASE_CONTROL};
    logic [7:0] msks [10] = '{8'hFF, MASK_CAPTURE_UNIT_TWO, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, MASK_STEERING, 8'hFF, 8'hFF, MASK_TIMEBASE_CONTROL};
    logic [7:0] cfgs [8] = '{8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h08, 8'h4C,
        8'hCC, 8'h00};
    logic [7:0] sdcs [5] = '{8'h00, 8'h05, 8'h0A, 8'h09, 8'h06};

    // ------------------------------------------------------------
    // Design and load
    // ------------------------------------------------------------
    pstr_steering i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pwm_raw(pwm_raw), .shutdown_evt(shutdown_evt),
        .port_out(port_out), .pwm_out(pwm_out), .pwm_out_oe(pwm_out_oe));
    pstr_load i_load (.drive(pwm_out), .drive_en(pwm_out_oe),
        .level(level));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    function automatic logic [31:0] xorshift();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    task automatic report_and_stop();
        if (errors == 0 && samples_checked > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: read %h not %h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: error flag %b", $time, got);
        end
    endtask

    // Pins settle one cycle after their cause, so wait before sampling
    task automatic chk_pins(input int edges);
        logic [3:0] eo, ee;
        logic [1:0] s;
        repeat (edges) @(posedge pclk);
        #1;
        for (int i = 0; i < 4; i++)
        begin
            s = (i % 2 == 0) ? sdc_m[3:2] : sdc_m[1:0];
            ee[i] = 1'b1;
            eo[i] = port_m[i];
            if (cfg_m[3:2] == 2'b11 && cfg_m[7:6] == 2'b00 && act_m[i])
            begin
                eo[i] = raw_m ^ cfg_m[1];
                if (evt_m || sdc_m[7])
                begin
                    ee[i] = ~s[1];
                    eo[i] = s[0];
                end
            end
        end
        samples_checked++;
        if (pwm_out_oe !== ee || ((level ^ eo) & ee) !== 4'h0)
        begin
            errors++;
            $display("unexpected at %0t: pins %b oe %b", $time, level,
                pwm_out_oe);
        end
    endtask

    // One APB transfer; waits for pready however long it takes
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic stim();
        logic [31:0] r;
        r = xorshift();
        @(posedge pclk);
        pwm_raw <= r[0];
        port_out <= r[7:4];
        raw_m = r[0];
        port_m = r[7:4];
    endtask

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (20000) @(posedge pclk);
        errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        report_and_stop();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {pwm_raw, shutdown_evt, port_out} = '0;
        {cfg_m, sdc_m, raw_m, evt_m, port_m} = '0;
        act_m = 8'h01;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        stim();
        chk_pins(2);
        for (int i = 0; i < 10; i++)
        begin
            apb(1'b0, offs[i], 32'h0);
            chk_rd(rd, {24'h0, rsts[i]});
        end
        // Read-only routing copy ignores writes; unmapped place errors
        apb(1'b1, OFF_ACTIVE_STEERING, 32'h0E);
        chk_resp(er, 1'b0);
        apb(1'b0, OFF_ACTIVE_STEERING, 32'h0);
        chk_rd(rd, 32'h01);
        apb(1'b1, 8'h2C, 32'hFF);
        chk_resp(er, 1'b1);
        for (int i = 0; i < 10; i++)
        begin
            apb(1'b1, offs[i], 32'hFFFF_FFFF);
            apb(1'b0, offs[i], 32'h0);
            chk_rd(rd, {24'h0, msks[i]});
        end
        apb(1'b1, OFF_TIMEBASE_CONTROL, 32'h0);
        apb(1'b1, OFF_SHUTDOWN_CONTROL, 32'h0);
        apb(1'b1, OFF_STEERING_CONTROL, 32'h0F);
        act_m = 8'h0F;
        foreach (cfgs[k])
        begin
            apb(1'b1, OFF_PWM_CAPTURE_CONTROL, {24'h0, cfgs[k]});
            cfg_m = cfgs[k];
            repeat (3)
            begin
                stim();
                chk_pins(2);
            end
        end
        // Immediate steering: new routing two edges after the write
        apb(1'b1, OFF_PWM_CAPTURE_CONTROL, 32'h0C);
        cfg_m = 8'h0C;
        apb(1'b1, OFF_STEERING_CONTROL, 32'h01);
        act_m = 8'h01;
        @(posedge pclk);
        pwm_raw <= 1'b1;
        port_out <= 4'h0;
        raw_m = 1'b1;
        port_m = 4'h0;
        apb(1'b1, OFF_STEERING_CONTROL, 32'h0A);
        chk_pins(1);
        act_m = 8'h0A;
        chk_pins(1);
        // Synced steering waits for the period match
        apb(1'b1, OFF_PERIOD_COMPARE, 32'h0F);
        apb(1'b1, OFF_TIMEBASE_COUNT, 32'h0);
        apb(1'b1, OFF_TIMEBASE_CONTROL, 32'h04);
        apb(1'b1, OFF_STEERING_CONTROL, 32'h15);
        chk_pins(3);
        act_m = 8'h05;
        chk_pins(20);
        apb(1'b0, OFF_ACTIVE_STEERING, 32'h0);
        chk_rd(rd, 32'h05);
        apb(1'b1, OFF_TIMEBASE_CONTROL, 32'h0);
        apb(1'b1, OFF_STEERING_CONTROL, 32'h05);
        // Shutdown touches steered pins only, and latches its status
        foreach (sdcs[k])
        begin
            apb(1'b1, OFF_SHUTDOWN_CONTROL, {24'h0, sdcs[k]});
            sdc_m = sdcs[k];
            stim();
            shutdown_evt <= 1'b1;
            evt_m = 1'b1;
            chk_pins(2);
            apb(1'b0, OFF_SHUTDOWN_CONTROL, 32'h0);
            chk_rd(rd, {24'h0, sdcs[k] | 8'h80});
            shutdown_evt <= 1'b0;
            evt_m = 1'b0;
            sdc_m = sdcs[k] | 8'h80;
            chk_pins(2);
            apb(1'b1, OFF_SHUTDOWN_CONTROL, {24'h0, sdcs[k]});
            sdc_m = sdcs[k];
            chk_pins(2);
        end
        report_and_stop();
    end
endmodule
